// ### hw/dcr_ctrl.sv
// Top of the dual-coil relay pulse controller, fixed-pulse variant.
// Assumes requests and enable are synchronous to clk.
`include "dcr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dcr_ctrl
    import dcr_pkg::*;
#(
    parameter logic [23:0] QUAL_CYCLES = 24'(`DCR_QUAL_CYCLES),
    parameter logic [23:0] PULSE_CYCLES = 24'(`DCR_PULSE_CYCLES)
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic enable,
    input wire logic request_1,
    input wire logic request_2,
    output logic drive_1,
    output logic drive_2
);
    logic [1:0] req;
    logic [1:0] qual;
    wire logic [1:0] drive_q;
    assign req = {request_2, request_1};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            dcr_chan_state_type state_q;
            dcr_chan_state_type state_d;
            logic drive_r_q;
            logic [`DCR_CNT_W-1:0] pulse_q;
            logic [`DCR_CNT_W-1:0] pulse_d;
            // Disabled time never counts toward qualification
            dcr_qual #(.QUAL_CYCLES(QUAL_CYCLES)) u_qual (
                .clk(clk),
                .reset_n(reset_n),
                .clk_en(clk_en),
                .request(req[ch]),
                .rearm(enable),
                .qualified(qual[ch])
            );
            // Other channel driving, qualified or stuck high blocks this one
            wire logic other_busy = drive_q[1-ch] || qual[1-ch];
            wire logic ready = (state_q == DCR_QUAL) && qual[ch];
            wire logic start = ready && !other_busy && enable;
            // A blocked qualification spends the edge; wait for a low
            wire logic blocked = ready && !start;
            wire logic done = (pulse_q >= PULSE_CYCLES - `DCR_CNT_ONE);
            wire logic abort = !enable;
            // Pulse timer runs to full length regardless of request width
            assign pulse_d = (state_q == DCR_DRIVE) ? pulse_q + `DCR_CNT_ONE : `DCR_CNT_ZERO;

            // Channel sequencing; every code is a legal state
            always_comb begin
                state_d = state_q;
                unique case (state_q)
                    DCR_IDLE: begin
                        if (req[ch]) begin
                            state_d = DCR_QUAL;
                        end
                    end
                    DCR_QUAL: begin
                        if (!req[ch]) begin
                            state_d = DCR_IDLE;
                        end else if (start) begin
                            state_d = DCR_DRIVE;
                        end else if (blocked) begin
                            state_d = DCR_WAIT_LOW;
                        end
                    end
                    DCR_DRIVE: begin
                        if (abort || done) begin
                            state_d = DCR_WAIT_LOW;
                        end
                    end
                    DCR_WAIT_LOW: begin
                        if (!req[ch]) begin
                            state_d = DCR_IDLE;
                        end
                    end
                endcase
            end

            // State, registered drive and pulse timer
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    state_q <= DCR_IDLE;
                    drive_r_q <= 1'b0;
                    pulse_q <= `DCR_CNT_ZERO;
                end else if (clk_en) begin
                    state_q <= state_d;
                    drive_r_q <= (state_d == DCR_DRIVE);
                    pulse_q <= pulse_d;
                end
            end
            assign drive_q[ch] = drive_r_q;
        end
    endgenerate

    assign drive_1 = drive_q[0];
    assign drive_2 = drive_q[1];

    // Never both coils at once
    never_both_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(drive_q[0] && drive_q[1]))
        else $error("both coils driven");
    // Enable low on an enabled cycle means outputs off next cycle
    en_abort_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && !enable) |=> !drive_q[0] && !drive_q[1])
        else $error("drive not aborted by enable");
    // Output rises only after a qualified request
    qual_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(drive_q[0]) |-> $past(qual[0]))
        else $error("drive without qualification");
    noise_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(drive_q[1]) |-> $past(qual[1]) && !$past(drive_q[0]))
        else $error("drive 2 on noise or overlap");
    overlap_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && drive_q[0]) |=> !$rose(drive_q[1]))
        else $error("second channel not suppressed");
    stuck_block_a: assert property (@(posedge clk) disable iff (!reset_n)
        (qual[0] && !drive_q[1]) |=> !drive_q[1])
        else $error("opposite coil driven while stuck");
    no_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!enable) |=> !$rose(drive_q[0]))
        else $error("pulse started while disabled");
    edge_only_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(drive_q[0]) && req[0] && enable |=> !drive_q[0])
        else $error("retrigger without new edge");
    // Own run counters, so the width checks do not lean on pulse_q
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chk
            logic [`DCR_CNT_W-1:0] run_q;
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    run_q <= `DCR_CNT_ZERO;
                end else if (clk_en) begin
                    run_q <= drive_q[ch] ? run_q + `DCR_CNT_ONE : `DCR_CNT_ZERO;
                end
            end
            sequence s_short_run;
                drive_q[ch] && enable && clk_en && (run_q < PULSE_CYCLES - `DCR_CNT_ONE);
            endsequence
            sequence s_full_run;
                drive_q[ch] && clk_en && (run_q == PULSE_CYCLES - `DCR_CNT_ONE);
            endsequence
            hold_width_a: assert property (@(posedge clk) disable iff (!reset_n)
                s_short_run |=> drive_q[ch])
                else $error("pulse ended early");
            end_width_a: assert property (@(posedge clk) disable iff (!reset_n)
                s_full_run |=> !drive_q[ch])
                else $error("pulse ran past its length");
        end
    endgenerate
endmodule
`default_nettype wire

// ### hw/dcr_map.svh
// Constants for the dual-coil relay pulse controller.
// Assumes a 200 MHz clock; included by bare name.
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
`define DCR_CLK_MHZ 200
`define DCR_QUAL_TIME_US 1000
`define DCR_PULSE_TIME_US 30000
`define DCR_QUAL_CYCLES (`DCR_QUAL_TIME_US * `DCR_CLK_MHZ)
`define DCR_PULSE_CYCLES (`DCR_PULSE_TIME_US * `DCR_CLK_MHZ)
`define DCR_CNT_W 24
`define DCR_CNT_ZERO 24'h000000
`define DCR_CNT_ONE 24'h000001
`endif

// ### hw/dcr_pkg.sv
// Types for the dual-coil relay pulse controller.
// Assumes nothing beyond a SystemVerilog compiler.
package dcr_pkg;
    typedef enum logic [1:0] {
        DCR_IDLE,
        DCR_QUAL,
        DCR_DRIVE,
        DCR_WAIT_LOW
    } dcr_chan_state_type;
endpackage

// ### hw/dcr_qual.sv
// One channel's request qualifier.
// Assumes request is synchronous to clk.
`include "dcr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dcr_qual #(
    parameter logic [23:0] QUAL_CYCLES = 24'(`DCR_QUAL_CYCLES)
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic request,
    input wire logic rearm,
    output logic qualified
);
    logic [`DCR_CNT_W-1:0] count_q;
    wire logic count_full = (count_q >= QUAL_CYCLES);

    // Count high width; rearm low keeps the count cleared
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= `DCR_CNT_ZERO;
        end else if (clk_en) begin
            if (!request || !rearm) begin
                count_q <= `DCR_CNT_ZERO;
            end else if (!count_full) begin
                count_q <= count_q + `DCR_CNT_ONE;
            end
        end
    end

    // Level output, so a stuck request keeps blocking the other side
    assign qualified = request && count_full;
endmodule
`default_nettype wire

// ### verif/dcr_coil_model.sv
// Behavioural pair of latching relay coils on the two drive outputs.
// Assumes drives are sampled on the controller clock.
`timescale 1ns/1ps
`default_nettype none
module dcr_coil_model (
    input wire logic clk,
    input wire logic drive_1,
    input wire logic drive_2,
    output logic latched_1,
    output logic overlap
);
    initial begin
        latched_1 = 1'b0;
        overlap = 1'b0;
    end
    // Both coils energised fight each other, so flag it for good
    always @(posedge clk) begin
        if (drive_1 && drive_2) begin
            overlap <= 1'b1;
        end else if (drive_1 || drive_2) begin
            latched_1 <= drive_1;
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the relay pulse controller, short counts.
// Assumes the coil model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [23:0] QC = 24'h000004;
    localparam logic [23:0] PC = 24'h000014;
    logic clk = 0, reset_n = 0, enable = 1, request_1 = 0, request_2 = 0, wch = 0, c, f;
    logic clk_en = 1;
    wire logic drive_1, drive_2, overlap, latched_1;
    int errors = 0, total_checks = 0, w = 0, r;
    logic q_ch[$];
    logic q_full[$];
    dcr_ctrl #(.QUAL_CYCLES(QC), .PULSE_CYCLES(PC)) DUT (.clk(clk), .reset_n(reset_n),
        .clk_en(clk_en), .enable(enable), .request_1(request_1), .request_2(request_2),
        .drive_1(drive_1), .drive_2(drive_2));
    dcr_coil_model coil (.clk(clk), .drive_1(drive_1), .drive_2(drive_2), .latched_1(latched_1),
        .overlap(overlap));
    initial forever #2.5 clk = ~clk;
    // Inputs move 1 ns after the edge, held for n cycles
    task automatic hold(input logic r1, input logic r2, input int n);
        request_1 = r1;
        request_2 = r2;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic expect_pulse(input logic ch, input logic full);
        q_ch.push_back(ch);
        q_full.push_back(full);
    endtask
    task automatic final_report;
        $display("errors=%0d total_checks=%0d", errors, total_checks);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Measure each drive pulse in enabled cycles, mid-cycle where it is settled
    always @(negedge clk) begin
        if (drive_1 === 1'b1 || drive_2 === 1'b1) begin
            if (w == 0) wch = drive_2;
            if (clk_en) w++;
        end else if (w != 0) begin
            total_checks++;
            c = ~wch;
            f = 1'b1;
            if (q_ch.size() > 0) begin
                c = q_ch.pop_front();
                f = q_full.pop_front();
            end
            if (c !== wch || (f ? w != PC : w >= PC)) begin
                errors++;
                $display("FAIL %0t pulse ch=%0d width=%0d", $time, wch, w);
            end
            w = 0;
        end
    end
    initial begin
        #20000;
        errors++;
        $display("FAIL %0t timeout", $time);
        final_report;
    end
    initial begin
        void'($urandom(71674));
        request_1 = 1'b1; // Stuck high from startup
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        expect_pulse(0, 1);
        hold(1, 0, 10);
        repeat (2) begin
            hold(1, 1, 8);
            hold(1, 0, 5);
        end
        hold(0, 0, 10);
        // Short glitches, the exact qualify width included
        for (int i = 0; i < 4; i++) begin
            r = (i == 0) ? 4 : 1 + $urandom % 4;
            hold(~i[0], i[0], r);
            hold(0, 0, 5);
        end
        for (int i = 0; i < 4; i++) begin
            expect_pulse(i[0], 1);
            hold(~i[0], i[0], 6 + $urandom % 40);
            hold(0, 0, 30);
        end
        expect_pulse(0, 1);
        hold(1, 0, 8);
        clk_en = 1'b0;
        hold(0, 0, 6);
        clk_en = 1'b1;
        hold(0, 0, 30);
        expect_pulse(0, 1);
        hold(1, 0, 8);
        hold(1, 1, 2);
        hold(1, 0, 3);
        hold(0, 1, 3);
        hold(0, 0, 30);
        expect_pulse(0, 1);
        hold(1, 0, 8);
        hold(0, 1, 12);
        hold(0, 0, 30);
        hold(1, 1, 10);
        hold(0, 0, 30);
        expect_pulse(1, 0);
        hold(0, 1, 12);
        enable = 1'b0;
        hold(0, 0, 10);
        hold(1, 0, 10);
        hold(0, 0, 30);
        enable = 1'b1;
        total_checks++;
        if (q_ch.size() != 0 || overlap !== 1'b0 || latched_1 !== 1'b0) begin
            errors++;
            $display("FAIL %0t missing pulse or overlap", $time);
        end
        final_report;
    end
endmodule
`default_nettype wire
